// File: timer16_irq_capture_compare.sv
// Interrupt flags, masks, compare and capture registers of two 16-bit timers.
// Assumes the counters, tick pulses and overflow pulses come from hclk logic.
`include "timer_irq_defs.svh"

module timer16_irq_capture_compare (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0][15:0] counter_value,
  input wire logic [1:0] timer_tick,
  input wire logic [1:0] counter_overflow,
  input wire logic [1:0][3:0] waveform_mode_bits,
  input wire logic [1:0] capture_in_pin,
  input wire logic analog_comp_out,
  input wire logic compat_fuse,
  input wire logic [1:0] force_cmp_a_strobe,
  input wire logic [1:0] force_cmp_b_strobe,
  input wire logic [1:0] force_cmp_c_strobe,
  input wire logic global_irq_en,
  input wire logic [7:0] vector_taken_main,
  input wire logic [7:0] vector_taken_ext,
  output logic [7:0] irq_req_main,
  output logic [7:0] irq_req_ext,
  output logic [1:0][2:0] waveform_match,
  output logic [1:0][15:0] capture_top
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  timer_irq_pkg::byte_t timer_irq_mask;
  timer_irq_pkg::byte_t ext_timer_irq_mask;
  timer_irq_pkg::byte_t timer_irq_flags;
  timer_irq_pkg::byte_t ext_flag_register;
  timer_irq_pkg::byte_t high_latch;
  logic acomp_sel;
  timer_irq_pkg::word_t cmp_value [2][3];
  timer_irq_pkg::word_t capture_value [2];

  // ----------------------------------------------------------------
  // Bus phase capture
  // ----------------------------------------------------------------
  logic addr_ok;
  logic dp_write;
  logic [7:0] dp_addr;
  logic [7:0] ap_addr;
  logic [31:0] next_rdata;
  logic ap_lo_read;
  timer_irq_pkg::word_t ap_wide;

  assign ap_addr = haddr[7:0];
  assign addr_ok = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= `RST_BYTE;
    end else begin
      dp_write <= addr_ok && hwrite;
      dp_addr <= ap_addr;
    end
  end

  // ----------------------------------------------------------------
  // Decode of the 16-bit register window
  // ----------------------------------------------------------------
  function automatic logic is_wide(input logic [7:0] a);
    is_wide = (a >= `ADDR_WIDE_FIRST) && (a <= `ADDR_WIDE_LAST) && (a[1:0] == 2'h0);
  endfunction : is_wide

  logic ap_t;
  logic dp_t;
  assign ap_t = ap_addr[6];
  assign dp_t = dp_addr[6];
  assign ap_wide = (ap_addr[4:3] == `CH_CAPTURE) ? capture_value[ap_t]
                 : cmp_value[ap_t][ap_addr[4:3]];
  assign ap_lo_read = addr_ok && !hwrite && is_wide(ap_addr) && !ap_addr[2];

  logic dp_wide_lo;
  logic dp_wide_hi;
  assign dp_wide_lo = dp_write && is_wide(dp_addr) && !dp_addr[2];
  assign dp_wide_hi = dp_write && is_wide(dp_addr) && dp_addr[2];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cap_meta;
  logic [1:0] cap_sync;
  logic [1:0] cap_prev;
  logic acomp_meta;
  logic acomp_sync;
  logic acomp_prev;
  logic compat_meta;
  logic compat_mode;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_meta <= 2'h0;
      cap_sync <= 2'h0;
      cap_prev <= 2'h0;
      acomp_meta <= 1'b0;
      acomp_sync <= 1'b0;
      acomp_prev <= 1'b0;
      compat_meta <= 1'b0;
      compat_mode <= 1'b0;
    end else begin
      cap_meta <= capture_in_pin;
      cap_sync <= cap_meta;
      cap_prev <= cap_sync;
      acomp_meta <= analog_comp_out;
      acomp_sync <= acomp_meta;
      acomp_prev <= acomp_sync;
      compat_meta <= compat_fuse;
      compat_mode <= compat_meta;
    end
  end

  // ----------------------------------------------------------------
  // Per-timer compare and capture
  // ----------------------------------------------------------------
  logic [1:0] cap_event;
  logic [1:0][2:0] cmp_event;

  for (genvar t = 0; t < 2; t++) begin : g_timer
    logic cap_is_top;
    logic pin_edge;
    logic [2:0] match_q;
    logic [2:0] force_s;
    assign force_s = {force_cmp_c_strobe[t], force_cmp_b_strobe[t], force_cmp_a_strobe[t]};
    assign cap_is_top = (waveform_mode_bits[t] == `MODE_PFC_CAP_TOP)
                     || (waveform_mode_bits[t] == `MODE_PC_CAP_TOP)
                     || (waveform_mode_bits[t] == `MODE_CTC_CAP_TOP)
                     || (waveform_mode_bits[t] == `MODE_FAST_CAP_TOP);
    if (t == 0) begin : g_src
      assign pin_edge = acomp_sel ? (acomp_sync && !acomp_prev)
                                  : (cap_sync[0] && !cap_prev[0]);
    end else begin : g_src
      assign pin_edge = cap_sync[1] && !cap_prev[1];
    end
    assign cap_event[t] = cap_is_top
      ? (timer_tick[t] && counter_value[t] == capture_value[t])
      : pin_edge;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        capture_value[t] <= `RST_WORD;
      end else if (!cap_is_top && pin_edge) begin
        capture_value[t] <= counter_value[t];
      end else if (dp_wide_lo && dp_t == 1'(t) && dp_addr[4:3] == `CH_CAPTURE) begin
        capture_value[t] <= {high_latch, hwdata[7:0]};
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        capture_top[t] <= `RST_WORD;
      end else begin
        capture_top[t] <= capture_value[t];
      end
    end

    for (genvar c = 0; c < 3; c++) begin : g_ch
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cmp_value[t][c] <= `RST_WORD;
        end else if (dp_wide_lo && dp_t == 1'(t) && dp_addr[4:3] == 2'(c)) begin
          cmp_value[t][c] <= {high_latch, hwdata[7:0]};
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          match_q[c] <= 1'b0;
          waveform_match[t][c] <= 1'b0;
        end else begin
          if (timer_tick[t]) begin
            match_q[c] <= (counter_value[t] == cmp_value[t][c]);
          end
          waveform_match[t][c] <= (timer_tick[t] && counter_value[t] == cmp_value[t][c])
                               || force_s[c];
        end
      end
      // The force strobe only reaches the waveform output.
      assign cmp_event[t][c] = timer_tick[t] && match_q[c];
    end
  end

  // ----------------------------------------------------------------
  // Shared high byte latch
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_latch <= `RST_BYTE;
    end else if (ap_lo_read) begin
      high_latch <= ap_wide[15:8];
    end else if (dp_wide_hi) begin
      high_latch <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Mask and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_irq_mask <= `RST_BYTE;
      ext_timer_irq_mask <= `RST_BYTE;
      acomp_sel <= 1'b0;
    end else if (dp_write) begin
      if (dp_addr == `ADDR_IRQ_MASK) begin
        timer_irq_mask <= hwdata[7:0] & `MAIN_BITS;
      end else if (dp_addr == `ADDR_EXT_IRQ_MASK && !compat_mode) begin
        ext_timer_irq_mask <= hwdata[7:0] & `EXT_BITS;
      end else if (dp_addr == `ADDR_CTRL) begin
        acomp_sel <= hwdata[`BIT_CTRL_ACOMP];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  timer_irq_pkg::byte_t set_main;
  timer_irq_pkg::byte_t set_ext;
  timer_irq_pkg::byte_t clr_main;
  timer_irq_pkg::byte_t clr_ext;

  always_comb begin
    set_main = `RST_BYTE;
    set_main[`BIT_CAP] = cap_event[0];
    set_main[`BIT_CMP_A] = cmp_event[0][0];
    set_main[`BIT_CMP_B] = cmp_event[0][1];
    set_main[`BIT_OVF] = counter_overflow[0];
    set_ext = `RST_BYTE;
    set_ext[`BIT_CAP] = cap_event[1];
    set_ext[`BIT_CMP_A] = cmp_event[1][0];
    set_ext[`BIT_CMP_B] = cmp_event[1][1];
    set_ext[`BIT_OVF] = counter_overflow[1];
    set_ext[`BIT_T3_CMP_C] = cmp_event[1][2];
    set_ext[`BIT_T1_CMP_C] = cmp_event[0][2];
  end

  assign clr_main = vector_taken_main
    | ((dp_write && dp_addr == `ADDR_IRQ_FLAGS) ? hwdata[7:0] : `RST_BYTE);
  assign clr_ext = vector_taken_ext
    | ((dp_write && dp_addr == `ADDR_EXT_FLAGS) ? hwdata[7:0] : `RST_BYTE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_irq_flags <= `RST_BYTE;
      ext_flag_register <= `RST_BYTE;
    end else begin
      timer_irq_flags <= ((timer_irq_flags & ~clr_main) | set_main) & `MAIN_BITS;
      ext_flag_register <= ((ext_flag_register & ~clr_ext) | set_ext) & `EXT_BITS;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  assign irq_req_main = global_irq_en ? (timer_irq_mask & timer_irq_flags) : `RST_BYTE;
  assign irq_req_ext = (global_irq_en && !compat_mode)
    ? (ext_timer_irq_mask & ext_flag_register) : `RST_BYTE;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (ap_addr == `ADDR_IRQ_MASK) begin
      next_rdata[7:0] = timer_irq_mask;
    end else if (ap_addr == `ADDR_EXT_IRQ_MASK) begin
      next_rdata[7:0] = compat_mode ? `RST_BYTE : ext_timer_irq_mask;
    end else if (ap_addr == `ADDR_IRQ_FLAGS) begin
      next_rdata[7:0] = timer_irq_flags;
    end else if (ap_addr == `ADDR_EXT_FLAGS) begin
      next_rdata[7:0] = ext_flag_register;
    end else if (ap_addr == `ADDR_CTRL) begin
      next_rdata[`BIT_CTRL_ACOMP] = acomp_sel;
    end else if (is_wide(ap_addr)) begin
      next_rdata[7:0] = ap_addr[2] ? high_latch : ap_wide[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

endmodule : timer16_irq_capture_compare

// File: timer_irq_defs.svh
// Constants of the timer interrupt, compare and capture block.
// Assumes byte registers, one per aligned 32-bit word of the AHB-Lite bus.
`ifndef TIMER_IRQ_DEFS_SVH
`define TIMER_IRQ_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_IRQ_MASK 8'h00
`define ADDR_EXT_IRQ_MASK 8'h04
`define ADDR_IRQ_FLAGS 8'h08
`define ADDR_EXT_FLAGS 8'h0c
`define ADDR_CTRL 8'h10
`define ADDR_WIDE_FIRST 8'h20
`define ADDR_WIDE_LAST 8'h5c

// ----------------------------------------------------------------
// Field positions and implemented bits
// ----------------------------------------------------------------
`define BIT_CAP 5
`define BIT_CMP_A 4
`define BIT_CMP_B 3
`define BIT_OVF 2
`define BIT_T3_CMP_C 1
`define BIT_T1_CMP_C 0
`define BIT_CTRL_ACOMP 0
`define MAIN_BITS 8'h3c
`define EXT_BITS 8'h3f
`define CH_CAPTURE 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

// ----------------------------------------------------------------
// Waveform modes that use the capture register as top
// ----------------------------------------------------------------
`define MODE_PFC_CAP_TOP 4'h8
`define MODE_PC_CAP_TOP 4'ha
`define MODE_CTC_CAP_TOP 4'hc
`define MODE_FAST_CAP_TOP 4'he

`endif

// File: timer_irq_pkg.sv
// Types of the timer interrupt, compare and capture block.
// Assumes nothing beyond the constants header.
package timer_irq_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
  typedef logic [3:0] mode_t;
endpackage : timer_irq_pkg

// File: timer_irq_asserts.sv
// Port checker of the timer interrupt, compare and capture block.
// Assumes it is bound into every instance of timer16_irq_capture_compare.
module timer_irq_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [1:0] timer_tick,
  input wire logic [1:0] counter_overflow,
  input wire logic compat_fuse,
  input wire logic [1:0] force_cmp_a_strobe,
  input wire logic global_irq_en,
  input wire logic [7:0] vector_taken_ext,
  input wire logic [7:0] irq_req_main,
  input wire logic [7:0] irq_req_ext,
  input wire logic [1:0][2:0] waveform_match
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  global_gate_a: assert property ((irq_req_main | irq_req_ext) != 8'h00 |-> global_irq_en)
    else $error("Request without global enable.");
  main_unused_a: assert property ((irq_req_main & 8'hc3) == 8'h00)
    else $error("Request on a foreign main bit.");
  ext_reserved_a: assert property (irq_req_ext[7:6] == 2'h0)
    else $error("Request on a reserved bit.");
  compat_off_a: assert property (compat_fuse [*3] |-> irq_req_ext == 8'h00)
    else $error("Extended request in legacy mode.");
  vector_clear_a: assert property (vector_taken_ext[2] && !counter_overflow[1] |=> !irq_req_ext[2])
    else $error("Taken vector left its flag.");
  match_cause_a: assert property (!timer_tick[0] && !force_cmp_a_strobe[0] |=> !waveform_match[0][0])
    else $error("Match pulse without a cause.");
  force_match_a: assert property (force_cmp_a_strobe[0] |=> waveform_match[0][0])
    else $error("Forced compare gave no match pulse.");
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("Bus answer not ready and okay.");
endmodule : timer_irq_asserts

bind timer16_irq_capture_compare timer_irq_asserts timer_irq_asserts_inst (.hclk, .hresetn,
  .hreadyout, .hresp, .timer_tick, .counter_overflow, .compat_fuse, .force_cmp_a_strobe,
  .global_irq_en, .vector_taken_ext, .irq_req_main, .irq_req_ext, .waveform_match);

// File: ahb_cpu_model.sv
// Processor model that makes single word transfers on the AHB-Lite bus.
// Assumes one slave whose hreadyout is fed back as hready.
module ahb_cpu_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Makes one transfer; a released bus shows the inverse of its last address and data.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~{24'h0, a};
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask : xfer
endmodule : ahb_cpu_model

// File: testbench.sv
// Self-checking bench of the timer interrupt, compare and capture block.
// Assumes the processor model drives the bus and this module the timer side.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, analog_comp_out, compat_fuse;
  logic global_irq_en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0] hsize;
  logic [1:0] htrans, timer_tick, counter_overflow, capture_in_pin;
  logic [1:0] force_cmp_a_strobe, force_cmp_b_strobe, force_cmp_c_strobe;
  logic [1:0][15:0] counter_value, capture_top;
  logic [1:0][3:0] waveform_mode_bits;
  logic [1:0][2:0] waveform_match;
  logic [7:0] vector_taken_main, vector_taken_ext, irq_req_main, irq_req_ext;
  int miscompares = 0;
  int samples_checked = 0;
  timer16_irq_capture_compare timer16_irq_capture_compare_inst (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .counter_value, .timer_tick, .counter_overflow, .waveform_mode_bits,
    .capture_in_pin, .analog_comp_out, .compat_fuse, .force_cmp_a_strobe,
    .force_cmp_b_strobe, .force_cmp_c_strobe, .global_irq_en, .vector_taken_main,
    .vector_taken_ext, .irq_req_main, .irq_req_ext, .waveform_match, .capture_top);
  ahb_cpu_model ahb_cpu_model_inst (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb_cpu_model_inst.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    ahb_cpu_model_inst.xfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd
  task automatic tick0();
    @(posedge hclk) timer_tick[0] <= 1'b1;
    @(posedge hclk) timer_tick[0] <= 1'b0;
  endtask : tick0
  task automatic t_regs();
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'hff);
    rd(8'h00, 32'h3c);
    wr(8'h04, 32'h3f);
    rd(8'h04, 32'h3f);
  endtask : t_regs
  task automatic t_compare();
    wr(8'h24, 32'h12);
    wr(8'h20, 32'h34);
    rd(8'h20, 32'h34);
    rd(8'h24, 32'h12);
    counter_value[0] <= 16'h1234;
    tick0();
    counter_value[0] <= 16'h0001;
    #1 check(waveform_match[0][0], 32'h1);
    rd(8'h08, 32'h0);
    tick0();
    rd(8'h08, 32'h10);
    #1 check(irq_req_main, 8'h10);
    @(posedge hclk) global_irq_en <= 1'b0;
    #1 check(irq_req_main, 8'h00);
    @(posedge hclk) global_irq_en <= 1'b1;
    wr(8'h08, 32'h00);
    rd(8'h08, 32'h10);
    wr(8'h08, 32'h10);
    rd(8'h08, 32'h0);
    @(posedge hclk) force_cmp_a_strobe[0] <= 1'b1;
    @(posedge hclk) force_cmp_a_strobe[0] <= 1'b0;
    #1 check(waveform_match[0][0], 32'h1);
    rd(8'h08, 32'h0);
  endtask : t_compare
  task automatic t_capture();
    counter_value[0] <= 16'habcd;
    capture_in_pin[0] <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(8'h38, 32'hcd);
    rd(8'h3c, 32'hab);
    check({16'h0, capture_top[0]}, 32'habcd);
    rd(8'h08, 32'h20);
    @(posedge hclk) vector_taken_main[5] <= 1'b1;
    @(posedge hclk) vector_taken_main[5] <= 1'b0;
    rd(8'h08, 32'h0);
    wr(8'h10, 32'h01);
    counter_value[0] <= 16'h5a5a;
    analog_comp_out <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(8'h38, 32'h5a);
    rd(8'h08, 32'h20);
  endtask : t_capture
  task automatic t_top();
    counter_value[0] <= 16'h0000;
    tick0();
    tick0();
    rd(8'h0c, 32'h01);
    rd(8'h08, 32'h28);
    #1 check(irq_req_ext, 8'h01);
    wr(8'h0c, 32'h01);
    wr(8'h08, 32'h28);
    waveform_mode_bits[1] <= 4'he;
    wr(8'h5c, 32'h01);
    wr(8'h58, 32'h10);
    counter_value[1] <= 16'h0777;
    capture_in_pin[1] <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(8'h58, 32'h10);
    rd(8'h5c, 32'h01);
    counter_value[1] <= 16'h0110;
    @(posedge hclk) timer_tick[1] <= 1'b1;
    @(posedge hclk) timer_tick[1] <= 1'b0;
    rd(8'h0c, 32'h20);
    check({16'h0, capture_top[1]}, 32'h0110);
    wr(8'h0c, 32'h20);
    rd(8'h0c, 32'h0);
  endtask : t_top
  task automatic t_overflow();
    @(posedge hclk) counter_overflow[1] <= 1'b1;
    @(posedge hclk) counter_overflow[1] <= 1'b0;
    rd(8'h0c, 32'h04);
    #1 check(irq_req_ext, 8'h04);
    @(posedge hclk) vector_taken_ext[2] <= 1'b1;
    @(posedge hclk) vector_taken_ext[2] <= 1'b0;
    rd(8'h0c, 32'h0);
    compat_fuse <= 1'b1;
    repeat (3) @(posedge hclk);
    rd(8'h04, 32'h0);
  endtask : t_overflow
  initial begin
    hresetn = 1'b0;
    counter_value = '0;
    timer_tick = 2'h0;
    counter_overflow = 2'h0;
    waveform_mode_bits = '0;
    capture_in_pin = 2'h0;
    analog_comp_out = 1'b0;
    compat_fuse = 1'b0;
    force_cmp_a_strobe = 2'h0;
    force_cmp_b_strobe = 2'h0;
    force_cmp_c_strobe = 2'h0;
    global_irq_en = 1'b1;
    vector_taken_main = 8'h00;
    vector_taken_ext = 8'h00;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_compare();
    t_capture();
    t_top();
    t_overflow();
    print_verdict();
  end
  initial begin
    #100us;
    miscompares++;
    print_verdict();
  end
endmodule : testbench
